// ==== inc/wake_gating_pkg.sv ====
`default_nettype none

package wake_gating_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STS_GRP1  = 8'h05;
  localparam logic [7:0] OFF_STS_GRP2  = 8'h06;
  localparam logic [7:0] OFF_EN_GRP1   = 8'h0B;
  localparam logic [7:0] OFF_EN_GRP2   = 8'h0C;
  localparam logic [7:0] OFF_CTRL      = 8'h20;
  localparam logic [7:0] OFF_IRQ_STS   = 8'h21;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h22;
  localparam logic [7:0] OFF_SRC_LEVEL = 8'h23;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MASTER_EN_BIT = 0;
  localparam int CTRL_BUS_LEVEL_BIT = 1;
  localparam int CTRL_REQ_DRIVE_BIT = 2;
  localparam int GRP2_SMI_BIT       = 3;
  localparam int IRQ_GRP1_BIT       = 0;
  localparam int IRQ_GRP2_BIT       = 1;
  localparam int IRQ_REQ_BIT        = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] EN_RESET   = 8'h00;
  localparam logic [7:0] STS_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET  = 8'h00;
  localparam logic [7:0] RD_IDLE    = 8'h00;

endpackage : wake_gating_pkg

`default_nettype wire

// ==== inc/wake_bank_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface wake_bank_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] event_in;
  logic             clr_wr;
  logic [WIDTH-1:0] clr_data;
  logic [WIDTH-1:0] status;
  logic             any_new;

  modport bank (
    input  event_in,
    input  clr_wr,
    input  clr_data,
    output status,
    output any_new
  );

  modport user (
    output event_in,
    output clr_wr,
    output clr_data,
    input  status,
    input  any_new
  );
endinterface : wake_bank_if

`default_nettype wire

// ==== hw/wake_status_bank.sv ====
`timescale 1ns/1ps
`default_nettype none

module wake_status_bank
  import wake_gating_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  wake_bank_if.bank bus
);

  logic [WIDTH-1:0] status_r;
  logic [WIDTH-1:0] status_nxt;
  logic             any_new_r;

  // ----------------------------------------------------------------
  // sticky status, write one to clear
  // ----------------------------------------------------------------
  // set beats clear so an event landing on the clearing write survives
  always_comb begin
    status_nxt = status_r;
    if (bus.clr_wr) begin
      status_nxt = status_nxt & ~bus.clr_data;
    end
    status_nxt = status_nxt | bus.event_in;
  end

  // of the resets, only the standby reset clears it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_r <= WIDTH'(STS_RESET);
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      any_new_r <= 1'b0;
    end else begin
      any_new_r <= |(bus.event_in & ~status_r);
    end
  end

  assign bus.status  = status_r;
  assign bus.any_new = any_new_r;

endmodule : wake_status_bank

`default_nettype wire

// ==== hw/pme_wake_enable_gating.sv ====
// Summary of operation
// - register 0x0B is read/write and its bits 0..7 enable group-one pins 0..7 as wake sources.
// - register 0x0C is read/write and its bits 0-2 and 4-7 enable group-two pins 0-2 and 4-7.
// - bit 3 of register 0x0C enables the grouped SMI source as a wake source instead of a pin.
// - the wake request output goes low when some source has enable, status and master enable all 1.
// - a disabled source still sets its status bit but never drives the wake request.
// - main-supply power-on, soft and hard resets leave both enable registers untouched.
// - a status bit sets on its source's wake event whatever the enables say.
// - writing 1 clears a status bit, writing 0 does nothing, so software clears with ones.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module pme_wake_enable_gating
  import wake_gating_pkg::*;
#(
  parameter int GRP_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              main_reset,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic [GRP_W-1:0]  gpio_grp1_wake,
  input  wire logic [GRP_W-1:0]  gpio_grp2_wake,
  input  wire logic              grouped_smi_wake_status,
  input  wire logic              wake_request_in_n,
  output logic                   wake_request_out_n,
  output logic                   wake_request_out_n_oe,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [GRP_W-1:0]  wake_enable_group_one_r;
  logic [GRP_W-1:0]  wake_enable_group_two_and_smi_r;
  logic              wake_master_enable_r;
  logic [2:0]        irq_sts_r;
  logic [2:0]        irq_sts_nxt;
  logic [2:0]        irq_mask_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              req_r;
  logic              req_nxt;
  logic              out_n_r;
  logic              irq_r;
  logic              bus_level_r;
  logic [GRP_W-1:0]  grp2_src;
  logic [GRP_W-1:0]  grp1_armed;
  logic [GRP_W-1:0]  grp2_armed;

  wake_bank_if #(.WIDTH(GRP_W)) grp1_if ();
  wake_bank_if #(.WIDTH(GRP_W)) grp2_if ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input logic             strobe,
                                  input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        off);
    wr_hit = strobe && (a == off);
  endfunction : wr_hit

  // a source is armed only when it has fired and software let it
  function automatic logic [GRP_W-1:0] armed(input logic [GRP_W-1:0] sts,
                                             input logic [GRP_W-1:0] en);
    armed = sts & en;
  endfunction : armed

  // ----------------------------------------------------------------
  // status banks
  // ----------------------------------------------------------------
  // bit 3 of group two carries the grouped smi source, not a pin
  always_comb begin
    grp2_src               = gpio_grp2_wake;
    grp2_src[GRP2_SMI_BIT] = grouped_smi_wake_status;
  end

  assign grp1_if.event_in = gpio_grp1_wake;
  assign grp1_if.clr_wr   = wr_hit(wr, addr, OFF_STS_GRP1);
  assign grp1_if.clr_data = wdata[GRP_W-1:0];
  assign grp2_if.event_in = grp2_src;
  assign grp2_if.clr_wr   = wr_hit(wr, addr, OFF_STS_GRP2);
  assign grp2_if.clr_data = wdata[GRP_W-1:0];

  wake_status_bank #(.WIDTH(GRP_W)) u_grp1_bank (
    .clk   (clk),
    .rst_b (rst_b),
    .bus   (grp1_if.bank)
  );

  wake_status_bank #(.WIDTH(GRP_W)) u_grp2_bank (
    .clk   (clk),
    .rst_b (rst_b),
    .bus   (grp2_if.bank)
  );

  // ----------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------
  // main_reset deliberately absent: the enables live on standby power
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_enable_group_one_r <= GRP_W'(EN_RESET);
    end else if (wr_hit(wr, addr, OFF_EN_GRP1)) begin
      wake_enable_group_one_r <= wdata[GRP_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_enable_group_two_and_smi_r <= GRP_W'(EN_RESET);
    end else if (wr_hit(wr, addr, OFF_EN_GRP2)) begin
      wake_enable_group_two_and_smi_r <= wdata[GRP_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_master_enable_r <= CTRL_RESET[CTRL_MASTER_EN_BIT];
    end else if (wr_hit(wr, addr, OFF_CTRL)) begin
      wake_master_enable_r <= wdata[CTRL_MASTER_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // wake request gating
  // ----------------------------------------------------------------
  assign grp1_armed = armed(grp1_if.status, wake_enable_group_one_r);
  assign grp2_armed = armed(grp2_if.status,
                            wake_enable_group_two_and_smi_r);

  always_comb begin
    req_nxt = wake_master_enable_r && (|grp1_armed || |grp2_armed);
  end

  // open drain: pull low while requesting, float otherwise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      req_r   <= 1'b0;
      out_n_r <= 1'b1;
    end else begin
      req_r   <= req_nxt;
      out_n_r <= ~req_nxt;
    end
  end

  // pad level is a plain synchronous input, kept for readback only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_level_r <= 1'b1;
    end else begin
      bus_level_r <= wake_request_in_n;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // new events set, write one clears, set wins
  always_comb begin
    irq_sts_nxt = irq_sts_r;
    if (wr_hit(wr, addr, OFF_IRQ_STS)) begin
      irq_sts_nxt = irq_sts_nxt & ~wdata[2:0];
    end
    irq_sts_nxt[IRQ_GRP1_BIT] = irq_sts_nxt[IRQ_GRP1_BIT] | grp1_if.any_new;
    irq_sts_nxt[IRQ_GRP2_BIT] = irq_sts_nxt[IRQ_GRP2_BIT] | grp2_if.any_new;
    irq_sts_nxt[IRQ_REQ_BIT]  = irq_sts_nxt[IRQ_REQ_BIT] | (req_nxt & ~req_r);
  end

  always_ff @(posedge clk) begin
    if (!rst_b || main_reset) begin
      irq_sts_r <= IRQ_RESET[2:0];
    end else begin
      irq_sts_r <= irq_sts_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || main_reset) begin
      irq_mask_r <= IRQ_RESET[2:0];
    end else if (wr_hit(wr, addr, OFF_IRQ_MASK)) begin
      irq_mask_r <= wdata[2:0];
    end
  end

  // mask bit 1 lets the matching status bit through
  always_ff @(posedge clk) begin
    if (!rst_b || main_reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_sts_nxt & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped offsets and reserved bits read zero
  always_comb begin
    rdata_nxt = RD_IDLE;
    if (rd) begin
      case (addr)
        OFF_STS_GRP1:  rdata_nxt = DATA_W'(grp1_if.status);
        OFF_STS_GRP2:  rdata_nxt = DATA_W'(grp2_if.status);
        OFF_EN_GRP1:   rdata_nxt = DATA_W'(wake_enable_group_one_r);
        OFF_EN_GRP2:   begin
          rdata_nxt = DATA_W'(wake_enable_group_two_and_smi_r);
        end
        OFF_CTRL:      begin
          rdata_nxt[CTRL_MASTER_EN_BIT] = wake_master_enable_r;
          rdata_nxt[CTRL_BUS_LEVEL_BIT] = bus_level_r;
          rdata_nxt[CTRL_REQ_DRIVE_BIT] = req_r;
        end
        OFF_IRQ_STS:   rdata_nxt = DATA_W'(irq_sts_r);
        OFF_IRQ_MASK:  rdata_nxt = DATA_W'(irq_mask_r);
        OFF_SRC_LEVEL: rdata_nxt = DATA_W'(gpio_grp1_wake);
        default:       rdata_nxt = RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r <= RD_IDLE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata                 = rdata_r;
  assign wake_request_out_n    = out_n_r;
  assign wake_request_out_n_oe = req_r;
  assign irq                   = irq_r;

endmodule : pme_wake_enable_gating

`default_nettype wire

// ==== sim/wake_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module wake_host_model (
  input  wire logic out_n,
  input  wire logic oe,
  output logic      bus_n,
  output int        wakes
);
  // ----
  // pulled-up wake line
  // ----
  // released line floats to the pull-up, never to the last value
  assign bus_n = oe ? out_n : 1'b1;
  initial wakes = 0;
  always @(negedge bus_n) wakes++;
endmodule : wake_host_model

`default_nettype wire

// ==== sim/wake_gating_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module wake_gating_assertions
  import wake_gating_pkg::*;
#(parameter int GRP_W = 8) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [GRP_W-1:0]  gpio_grp1_wake,
  input wire logic [GRP_W-1:0]  gpio_grp2_wake,
  input wire logic              grouped_smi_wake_status,
  input wire logic              wake_request_out_n,
  input wire logic              wake_request_out_n_oe
);
  // ----
  // shadow state
  // ----
  // main_reset is not watched: enables and status ignore it
  logic [7:0] e1_r, e2_r, s1_r, s2_r, ev2, c1, c2;
  logic       m_r, req_c;
  assign ev2 = {gpio_grp2_wake[7:4], grouped_smi_wake_status,
                gpio_grp2_wake[2:0]};
  assign c1 = (wr && addr == OFF_STS_GRP1) ? wdata : 8'h00;
  assign c2 = (wr && addr == OFF_STS_GRP2) ? wdata : 8'h00;
  assign req_c = m_r && |((e1_r & s1_r) | (e2_r & s2_r));
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {e1_r, e2_r, s1_r, s2_r, m_r} <= '0;
    end else begin
      if (wr && addr == OFF_EN_GRP1) e1_r <= wdata;
      if (wr && addr == OFF_EN_GRP2) e2_r <= wdata;
      if (wr && addr == OFF_CTRL) m_r <= wdata[CTRL_MASTER_EN_BIT];
      s1_r <= (s1_r & ~c1) | gpio_grp1_wake;
      s2_r <= (s2_r & ~c2) | ev2;
    end
  end
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_req_gating: assert property (
    wake_request_out_n == !$past(req_c)) else $error("request mismatch");
  chk_master_off: assert property (!m_r |=> wake_request_out_n)
    else $error("request without master enable");
  chk_oe_pairs: assert property (
    wake_request_out_n_oe == !wake_request_out_n)
    else $error("enable and level disagree");
  chk_en1_read: assert property (rd && addr == OFF_EN_GRP1
    |=> rdata == $past(e1_r)) else $error("enable one readback");
  chk_en2_read: assert property (rd && addr == OFF_EN_GRP2
    |=> rdata == $past(e2_r)) else $error("enable two readback");
  chk_sts1_read: assert property (rd && addr == OFF_STS_GRP1
    |=> rdata == $past(s1_r)) else $error("status one readback");
  chk_sts2_read: assert property (rd && addr == OFF_STS_GRP2
    |=> rdata == $past(s2_r)) else $error("status two readback");
  chk_rdata_idle: assert property (!rd |=> rdata == RD_IDLE)
    else $error("read data outside read slot");
  cover property (!wake_request_out_n);
  cover property (|c1 && |s1_r);
  cover property (rd && addr == OFF_EN_GRP2 && e2_r[GRP2_SMI_BIT]);
endmodule : wake_gating_assertions

bind pme_wake_enable_gating wake_gating_assertions #(.GRP_W(GRP_W)) i_chk (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .gpio_grp1_wake(gpio_grp1_wake),
  .gpio_grp2_wake(gpio_grp2_wake),
  .grouped_smi_wake_status(grouped_smi_wake_status),
  .wake_request_out_n(wake_request_out_n),
  .wake_request_out_n_oe(wake_request_out_n_oe));

`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top import wake_gating_pkg::*; ();
  logic       clk = 1'b0, rst_b = 1'b0, main_reset = 1'b0, wr = 1'b0;
  logic       rd = 1'b0, smi = 1'b0, m, s, lo;
  logic [7:0] addr = 8'h00, wdata = 8'h00, g1 = 8'h00, g2 = 8'h00;
  logic [7:0] v1, v2, e1, e2;
  wire  [7:0] rdata;
  wire        out_n, oe, irq, bus_n;
  int         wakes, mismatches = 0, samples_checked = 0, exp_wakes = 0;
  int         seed = 32'hcfb9_f4c1;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

  always #20 clk = ~clk;
  pme_wake_enable_gating i_pme_wake_enable_gating (.clk(clk), .rst_b(rst_b),
    .main_reset(main_reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .gpio_grp1_wake(g1), .gpio_grp2_wake(g2),
    .grouped_smi_wake_status(smi), .wake_request_in_n(bus_n),
    .wake_request_out_n(out_n), .wake_request_out_n_oe(oe), .irq(irq));
  wake_host_model i_wake_host_model (.out_n(out_n), .oe(oe), .bus_n(bus_n),
    .wakes(wakes));

  // ----
  // helpers
  // ----
  function automatic logic [7:0] sts2(input logic [7:0] e, input logic q);
    return {e[7:4], q, e[2:0]};
  endfunction : sts2
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge clk);
  endtask : rchk
  // one-cycle event, then wait out status plus request latency
  task automatic pulse(input logic [7:0] a, input logic [7:0] b,
                       input logic q);
    g1 <= a;
    g2 <= b;
    smi <= q;
    @(posedge clk);
    g1 <= 8'h00;
    g2 <= 8'h00;
    smi <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // ----
  // sequence
  // ----
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk(OFF_EN_GRP1, EN_RESET);
    rchk(OFF_EN_GRP2, EN_RESET);
    for (int i = 0; i < 4; i++) begin
      v1 = 8'($random(seed));
      v2 = 8'($random(seed));
      wreg(OFF_EN_GRP1, v1);
      wreg(OFF_EN_GRP2, v2);
      wreg(8'h3f, 8'hff);
      rchk(OFF_EN_GRP1, v1);
      rchk(OFF_EN_GRP2, v2);
      rchk(8'h3f, RD_IDLE);
    end
    main_reset <= 1'b1;
    @(posedge clk);
    main_reset <= 1'b0;
    @(posedge clk);
    rchk(OFF_EN_GRP1, v1);
    rchk(OFF_EN_GRP2, v2);
    $display("test registers done");
    wreg(OFF_IRQ_MASK, 8'h07);
    for (int i = 0; i < 14; i++) begin
      {v1, v2, e1, e2} = $random(seed);
      s = 1'($random(seed));
      m = (i != 3);
      case (i)
        0: {v1, v2, e1} = {8'h00, 8'h00, 8'hff};
        1: {v1, v2, e1, e2, s} = {8'h00, 8'h08, 8'h00, 8'hf7, 1'b1};
        2: {v1, v2, e1, e2, s} = {8'h00, 8'h08, 8'h00, 8'h08, 1'b0};
        default: ;
      endcase
      wreg(OFF_CTRL, {7'h00, m});
      wreg(OFF_EN_GRP1, v1);
      wreg(OFF_EN_GRP2, v2);
      pulse(e1, e2, s);
      lo = m && |((v1 & e1) | (v2 & sts2(e2, s)));
      exp_wakes += int'(lo);
      `CHK(bus_n, !lo)
      rchk(OFF_CTRL, {5'h00, lo, !lo, m});
      rchk(OFF_STS_GRP1, e1);
      rchk(OFF_STS_GRP2, sts2(e2, s));
      `CHK(irq, |{e1, sts2(e2, s)})
      wreg(OFF_STS_GRP1, 8'h00);
      rchk(OFF_STS_GRP1, e1);
      wreg(OFF_STS_GRP1, 8'hff);
      wreg(OFF_STS_GRP2, 8'hff);
      wreg(OFF_IRQ_STS, 8'hff);
      @(posedge clk);
      `CHK(bus_n, 1'b1)
      `CHK(irq, 1'b0)
    end
    `CHK(wakes, exp_wakes)
    wreg(OFF_IRQ_MASK, 8'h00);
    pulse(8'h01, 8'h00, 1'b0);
    @(posedge clk);
    `CHK(irq, 1'b0)
    $display("test wake gating done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk(OFF_EN_GRP1, EN_RESET);
    rchk(OFF_EN_GRP2, EN_RESET);
    // idle wake line sits at its pull-up, so the level bit reads one
    rchk(OFF_CTRL, CTRL_RESET | (8'h01 << CTRL_BUS_LEVEL_BIT));
    g1 <= 8'h5a;
    rchk(OFF_SRC_LEVEL, 8'h5a);
    g1 <= 8'h00;
    $display("test standby reset done");
    final_report();
  end
endmodule : tb_top

`default_nettype wire
